// ==== src/paired_timer_pkg.sv ====
// Shared constants for the paired general purpose timer block
package paired_timer_pkg;

    // Data and prescaler widths, timer and pair counts
    localparam int DW = 16;
    localparam int PW = 8;
    localparam int NT = 4;
    localparam int NP = 2;

    // Timer order: pair a lower, pair a upper, pair b lower, pair b upper
    localparam logic [15:0] OFS_CNT [NT] = '{16'h0106, 16'h010A, 16'h0114, 16'h0118};
    localparam logic [15:0] OFS_PER [NT] = '{16'h010C, 16'h010E, 16'h011A, 16'h011C};
    localparam logic [15:0] OFS_CTL [NT] = '{16'h0110, 16'h0112, 16'h011E, 16'h0120};
    localparam logic [15:0] OFS_HOLD [NP] = '{16'h0108, 16'h0116};
    localparam logic [15:0] OFS_IRQ_FLAG = 16'h0122;
    localparam logic [15:0] OFS_IRQ_ENABLE = 16'h0124;

    // Reset values
    localparam logic [15:0] PER_RST = 16'hFFFF;
    localparam logic [15:0] CTL_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [3:0] FLAG_RST = 4'h0;

    // Control register fields
    localparam int B_RUN = 15;
    localparam int B_IDLE = 13;
    localparam int B_GATE = 6;
    localparam int B_DIV_HI = 5;
    localparam int B_DIV_LO = 4;
    localparam int B_CHAIN = 3;
    localparam int B_SRC = 1;
    localparam logic [15:0] CTL_WMASK_LO = 16'hA07A;
    localparam logic [15:0] CTL_WMASK_UP = 16'hA072;

    // Interrupt flag and enable bit positions
    localparam int IRQ_A_LO = 0;
    localparam int PAIR_A_IRQ_FLAG = 1;
    localparam int IRQ_B_LO = 2;
    localparam int PAIR_B_IRQ_FLAG = 3;

    // Last prescaler count for divide by 1, 8, 64, 256
    localparam logic [PW-1:0] DIV_LAST [4] = '{8'h00, 8'h07, 8'h3F, 8'hFF};

endpackage : paired_timer_pkg

// ==== src/prescale_divider.sv ====
// Clock prescaler for one timer: passes every 1st, 8th, 64th or 256th tick
`timescale 1ns/100ps
`default_nettype none
module prescale_divider
    import paired_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic clear,
    input wire logic tick_in,
    input wire logic [1:0] div_sel,
    // Divided tick
    output logic tick_out
);

    logic [PW-1:0] cnt_q;
    logic [PW-1:0] cnt_d;

    always_comb
    begin
        cnt_d = cnt_q;
        tick_out = 1'b0;
        // A clear swallows a coincident tick so the count restarts cleanly
        if (clear)
        begin
            cnt_d = '0;
        end
        else if (tick_in)
        begin
            if (cnt_q >= DIV_LAST[div_sel])
            begin
                cnt_d = '0;
                tick_out = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + PW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

endmodule : prescale_divider
`default_nettype wire

// ==== src/paired_gp_timer.sv ====
// Two pairs of 16-bit timers, each pair chainable into one 32-bit timer
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Pair a upper match pulses adc trigger
// - Prescale input by 1, 8, 64, 256
// - Chained pair uses lower clock and prescaler
// - Count or control write clears prescaler when run bit set
// - Stopped timer keeps its prescaler count
// - Control write leaves count untouched
// - Sleep stops all counting
// - Chained match or gate fall sets upper flag
// - Pair b has no adc trigger
// - Only pair a gives time bases
// - Lower is low half, upper high half
// - Chained pair obeys lower control only
// - Chained count wraps to zero after period
// - Lower count read latches upper into holding
// - Chained lower count write loads upper from holding
// - Gated mode counts while gate high
module paired_gp_timer
    import paired_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [15:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DW-1:0] rdata,
    // Processor power state
    input wire logic sleep_mode,
    input wire logic idle_mode,
    // External clock or gate pins, one per timer
    input wire logic [NT-1:0] ext_clk_pin,
    // Events and time bases
    output logic irq,
    output logic adc_trigger,
    output logic [DW-1:0] pair_a_lower_time_base,
    output logic [DW-1:0] pair_a_upper_time_base
);

    // Pin synchronisers
    logic [NT-1:0] s1_q;
    logic [NT-1:0] s2_q;
    logic [NT-1:0] s3_q;
    logic [NT-1:0] lvl_q;
    logic [NT-1:0] lvl_d;
    logic [NT-1:0] pin_rise;
    logic [NT-1:0] pin_fall;

    // Timer state
    logic [DW-1:0] cnt_q [NT];
    logic [DW-1:0] cnt_d [NT];
    logic [DW-1:0] per_q [NT];
    logic [DW-1:0] per_d [NT];
    logic [DW-1:0] ctl_q [NT];
    logic [DW-1:0] ctl_d [NT];
    logic [DW-1:0] hold_q [NP];
    logic [DW-1:0] hold_d [NP];
    logic [NT-1:0] ev;
    logic trig_d;
    logic adc_trigger_q;

    // Decode and prescaler hookup
    logic [NT-1:0] wr_cnt;
    logic [NT-1:0] wr_per;
    logic [NT-1:0] wr_ctl;
    logic [NT-1:0] run;
    logic [NT-1:0] pre_in;
    logic [NT-1:0] pre_clr;
    logic [NT-1:0] tick;
    logic [NT-1:0] gate_fall;

    // Interrupts and read port
    logic [3:0] flag_q;
    logic [3:0] flag_d;
    logic [3:0] enable_q;
    logic [3:0] enable_d;
    logic irq_q;
    logic irq_d;
    logic [DW-1:0] rdata_q;
    logic [DW-1:0] rdata_d;

    // A pin level counts only once the second and third stage agree
    always_comb
    begin
        lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
        pin_rise = lvl_d & ~lvl_q;
        pin_fall = ~lvl_d & lvl_q;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end
        else
        begin
            s1_q <= ext_clk_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NT; i++)
        begin
            wr_cnt[i] = wr && (addr == OFS_CNT[i]);
            wr_per[i] = wr && (addr == OFS_PER[i]);
            wr_ctl[i] = wr && (addr == OFS_CTL[i]);
            // Clocks are gated off in sleep, and in idle when asked
            run[i] = ctl_q[i][B_RUN] && !sleep_mode && !(idle_mode && ctl_q[i][B_IDLE]);
            if (ctl_q[i][B_SRC])
                pre_in[i] = run[i] && pin_rise[i];
            else if (ctl_q[i][B_GATE])
                pre_in[i] = run[i] && lvl_q[i];
            else
                pre_in[i] = run[i];
            gate_fall[i] = run[i] && ctl_q[i][B_GATE] && !ctl_q[i][B_SRC] && pin_fall[i];
            // A prescaler whose run bit is clear cannot be cleared; one halted by sleep or idle still can
            pre_clr[i] = ctl_q[i][B_RUN] && (wr_cnt[i] || wr_ctl[i]);
        end
        for (int p = 0; p < NP; p++)
        begin
            if (ctl_q[2*p][B_CHAIN])
            begin
                // Upper prescaler sits idle while chained
                pre_in[2*p+1] = 1'b0;
                gate_fall[2*p+1] = 1'b0;
                pre_clr[2*p] = ctl_q[2*p][B_RUN] && (wr_cnt[2*p] || wr_cnt[2*p+1]
                    || wr_ctl[2*p] || wr_ctl[2*p+1]);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NT; g++)
        begin : g_pre
            prescale_divider u_pre (
                .clk(clk),
                .nrst(nrst),
                .clear(pre_clr[g]),
                .tick_in(pre_in[g]),
                .div_sel(ctl_q[g][B_DIV_HI:B_DIV_LO]),
                .tick_out(tick[g])
            );
        end
    endgenerate

    always_comb
    begin
        logic [31:0] c32;
        int lo;
        int up;
        c32 = '0;
        lo = 0;
        up = 0;
        cnt_d = cnt_q;
        per_d = per_q;
        ctl_d = ctl_q;
        hold_d = hold_q;
        ev = '0;
        trig_d = 1'b0;
        for (int p = 0; p < NP; p++)
        begin
            lo = 2 * p;
            up = lo + 1;
            if (ctl_q[lo][B_CHAIN])
            begin
                if (tick[lo])
                begin
                    // Lower half is least significant
                    if ({cnt_q[up], cnt_q[lo]} == {per_q[up], per_q[lo]})
                    begin
                        c32 = '0;
                        ev[up] = 1'b1;
                        trig_d = trig_d || (p == 0);
                    end
                    else
                    begin
                        c32 = {cnt_q[up], cnt_q[lo]} + 32'h0000_0001;
                    end
                    cnt_d[lo] = c32[15:0];
                    cnt_d[up] = c32[31:16];
                end
                if (gate_fall[lo])
                    ev[up] = 1'b1;
            end
            else
            begin
                for (int t = lo; t <= up; t++)
                begin
                    if (tick[t])
                    begin
                        if (cnt_q[t] == per_q[t])
                        begin
                            cnt_d[t] = CNT_RST;
                            ev[t] = 1'b1;
                            trig_d = trig_d || (t == 1);
                        end
                        else
                        begin
                            cnt_d[t] = cnt_q[t] + DW'(1);
                        end
                    end
                    if (gate_fall[t])
                        ev[t] = 1'b1;
                end
            end
            // Software access overrides counting in the same cycle
            if (rd && addr == OFS_CNT[lo])
                hold_d[p] = cnt_q[up];
            if (wr && addr == OFS_HOLD[p])
                hold_d[p] = wdata;
            if (wr_cnt[up])
                cnt_d[up] = wdata;
            if (wr_cnt[lo])
            begin
                cnt_d[lo] = wdata;
                if (ctl_q[lo][B_CHAIN])
                    cnt_d[up] = hold_q[p];
            end
            if (wr_per[lo])
                per_d[lo] = wdata;
            if (wr_per[up])
                per_d[up] = wdata;
            // Control writes touch only control bits, never the count
            if (wr_ctl[lo])
                ctl_d[lo] = wdata & CTL_WMASK_LO;
            if (wr_ctl[up])
                ctl_d[up] = wdata & CTL_WMASK_UP;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NT; i++)
            begin
                cnt_q[i] <= CNT_RST;
                per_q[i] <= PER_RST;
                ctl_q[i] <= CTL_RST;
            end
            for (int p = 0; p < NP; p++)
                hold_q[p] <= CNT_RST;
            adc_trigger_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            per_q <= per_d;
            ctl_q <= ctl_d;
            hold_q <= hold_d;
            adc_trigger_q <= trig_d;
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_comb
    begin
        flag_d = flag_q;
        if (wr && addr == OFS_IRQ_FLAG)
            flag_d = flag_q & ~wdata[3:0];
        flag_d = flag_d | ev;
        enable_d = enable_q;
        if (wr && addr == OFS_IRQ_ENABLE)
            enable_d = wdata[3:0];
        irq_d = |(flag_d & enable_d);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            flag_q <= FLAG_RST;
            enable_q <= FLAG_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
            enable_q <= enable_d;
            irq_q <= irq_d;
        end
    end

    // Unmapped reads return zero
    always_comb
    begin
        rdata_d = '0;
        if (rd)
        begin
            for (int i = 0; i < NT; i++)
            begin
                if (addr == OFS_CNT[i])
                    rdata_d = cnt_q[i];
                if (addr == OFS_PER[i])
                    rdata_d = per_q[i];
                if (addr == OFS_CTL[i])
                    rdata_d = ctl_q[i];
            end
            for (int p = 0; p < NP; p++)
            begin
                if (addr == OFS_HOLD[p])
                    rdata_d = hold_q[p];
            end
            if (addr == OFS_IRQ_FLAG)
                rdata_d = {12'h000, flag_q};
            if (addr == OFS_IRQ_ENABLE)
                rdata_d = {12'h000, enable_q};
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata_q <= '0;
        else
            rdata_q <= rdata_d;
    end

    assign rdata = rdata_q;
    assign irq = irq_q;
    assign adc_trigger = adc_trigger_q;
    // Pair b counts stay internal
    assign pair_a_lower_time_base = cnt_q[0];
    assign pair_a_upper_time_base = cnt_q[1];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_ctl_keeps_count;
        (wr && addr == OFS_CTL[0] && ctl_q[0][B_RUN]) |=> $stable(cnt_q[0]);
    endproperty
    a_ctl_keeps_count: assert property (p_ctl_keeps_count)
        else $error("control write changed the count");

    property p_sleep_halts;
        (sleep_mode && !wr) |=> $stable(cnt_q[0]) && $stable(cnt_q[3]);
    endproperty
    a_sleep_halts: assert property (p_sleep_halts)
        else $error("count moved during sleep");

    property p_trig_on_match;
        adc_trigger_q |-> $past(cnt_q[1]) == $past(per_q[1]) && $past(tick[0] || tick[1]);
    endproperty
    a_trig_on_match: assert property (p_trig_on_match)
        else $error("adc trigger without upper match");

    property p_hold_latch;
        (rd && addr == OFS_CNT[0] && !(wr && addr == OFS_HOLD[0]))
            |=> hold_q[0] == $past(cnt_q[1]);
    endproperty
    a_hold_latch: assert property (p_hold_latch)
        else $error("holding register not latched on lower read");

    property p_hold_load;
        (wr && addr == OFS_CNT[0] && ctl_q[0][B_CHAIN]) |=> cnt_q[1] == $past(hold_q[0]);
    endproperty
    a_hold_load: assert property (p_hold_load)
        else $error("upper count not loaded from holding");

    sequence s_chain_wrap;
        tick[0] && ctl_q[0][B_CHAIN] && !wr && cnt_q[0] == per_q[0] && cnt_q[1] == per_q[1];
    endsequence

    property p_chain_wrap;
        s_chain_wrap |=> cnt_q[0] == CNT_RST && cnt_q[1] == CNT_RST && flag_q[PAIR_A_IRQ_FLAG];
    endproperty
    a_chain_wrap: assert property (p_chain_wrap)
        else $error("chained wrap or upper flag missing");

    property p_flag_sticky;
        (flag_q[PAIR_A_IRQ_FLAG] && !(wr && addr == OFS_IRQ_FLAG))
            |=> flag_q[PAIR_A_IRQ_FLAG];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag cleared without software");

    property p_single_wrap;
        (tick[3] && !ctl_q[2][B_CHAIN] && !wr && cnt_q[3] == per_q[3])
            |=> cnt_q[3] == CNT_RST && flag_q[PAIR_B_IRQ_FLAG];
    endproperty
    a_single_wrap: assert property (p_single_wrap)
        else $error("single timer did not wrap");

    property p_irq_level;
        irq_q == |(flag_q & enable_q);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt output disagrees with flags");

    property p_gate_hold;
        (ctl_q[0][B_GATE] && !ctl_q[0][B_SRC] && !ctl_q[0][B_CHAIN] && !lvl_q[0] && !wr)
            |=> $stable(cnt_q[0]);
    endproperty
    a_gate_hold: assert property (p_gate_hold)
        else $error("gated count moved with gate low");

    c_chain_wrap: cover property (s_chain_wrap);
    c_adc_trig: cover property (adc_trigger_q);
    c_gate_fall: cover property (gate_fall[0]);
    c_irq: cover property ($rose(irq_q));

endmodule : paired_gp_timer
`default_nettype wire

// ==== bench/soft_master.sv ====
// Register bus master standing in for processor software
`timescale 1ns/100ps
`default_nettype none
module soft_master
    import paired_timer_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output logic [15:0] addr,
    output logic [DW-1:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [DW-1:0] rdata
);
    initial
    begin
        addr = 16'h0000;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end

    // One-cycle write strobe; also how software clears a flag
    task automatic wr16(input logic [15:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr16

    // Data stands only in the cycle after the strobe
    task automatic rd16(input logic [15:0] a, output logic [DW-1:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd16

    // Holding first, then lower count, for a whole 32-bit load
    task automatic wr32(input logic [15:0] hold_a, input logic [15:0] lo_a, input logic [31:0] v);
        wr16(hold_a, v[31:16]);
        wr16(lo_a, v[15:0]);
    endtask : wr32
endmodule : soft_master
`default_nettype wire

// ==== bench/test_paired_gp_timer.sv ====
// Self-checking testbench for the paired timer block
`timescale 1ns/100ps
`default_nettype none
module test_paired_gp_timer
    import paired_timer_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
    logic [DW-1:0] rdata;
    logic sleep_mode = 1'b0;
    logic idle_mode = 1'b0;
    logic [NT-1:0] ext_clk_pin = 4'h0;
    logic irq;
    logic adc_trigger;
    logic [DW-1:0] tb_lo;
    logic [DW-1:0] tb_up;
    logic [DW-1:0] v;
    int failures = 0;
    int cmp_count = 0;

    always #5 clk = ~clk;

    soft_master u_soft_master (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));

    paired_gp_timer u_paired_gp_timer (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
        .ext_clk_pin(ext_clk_pin), .irq(irq), .adc_trigger(adc_trigger),
        .pair_a_lower_time_base(tb_lo), .pair_a_upper_time_base(tb_up));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic close_out();
        $display("failures=%0d comparisons=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic reset_values();
        for (int i = 0; i < NT; i++)
        begin
            u_soft_master.rd16(OFS_PER[i], v);
            chk(v, PER_RST);
            u_soft_master.rd16(OFS_CTL[i], v);
            chk(v, CTL_RST);
        end
        u_soft_master.rd16(16'h0130, v);
        chk(v, 16'h0000);
    endtask : reset_values

    task automatic single_wrap();
        int n;
        u_soft_master.wr16(OFS_PER[0], 16'h0002);
        u_soft_master.wr16(OFS_IRQ_ENABLE, 16'h0001);
        u_soft_master.wr16(OFS_CTL[0], 16'h8000);
        n = 0;
        while (tb_lo !== 16'h0002 && n < 20)
        begin
            tick(1);
            n++;
        end
        tick(1);
        chk(tb_lo, 16'h0000);
        tick(2);
        chk(irq, 1'b1);
        u_soft_master.wr16(OFS_IRQ_ENABLE, 16'h0000);
        tick(2);
        chk(irq, 1'b0);
        u_soft_master.wr16(OFS_CTL[0], 16'h0000);
        u_soft_master.wr16(OFS_IRQ_FLAG, 16'h000F);
        u_soft_master.rd16(OFS_IRQ_FLAG, v);
        chk(v, 16'h0000);
    endtask : single_wrap

    task automatic measure(input int exp);
        logic [DW-1:0] s;
        int n;
        tick(1);
        for (int k = 0; k < 2; k++)
        begin
            s = tb_lo;
            n = 0;
            while (tb_lo === s && n < 600)
            begin
                tick(1);
                n++;
            end
        end
        chk(n, exp);
    endtask : measure

    task automatic prescale();
        int divs [4] = '{1, 8, 64, 256};
        u_soft_master.wr16(OFS_PER[0], 16'hFFFF);
        for (int s = 0; s < 4; s++)
        begin
            u_soft_master.wr16(OFS_CTL[0], 16'h8000 | 16'(s << 4));
            measure(divs[s]);
        end
        // Count write restarts the divide by 8 from zero
        u_soft_master.wr16(OFS_CTL[0], 16'h8010);
        u_soft_master.wr16(OFS_CNT[0], 16'h0000);
        tick(7);
        chk(tb_lo, 16'h0000);
        tick(1);
        chk(tb_lo, 16'h0001);
        u_soft_master.wr16(OFS_CTL[0], 16'h0000);
        u_soft_master.wr16(OFS_CNT[0], 16'h0005);
        u_soft_master.wr16(OFS_CTL[0], 16'h0010);
        u_soft_master.rd16(OFS_CNT[0], v);
        chk(v, 16'h0005);
    endtask : prescale

    task automatic chained();
        int n;
        u_soft_master.wr16(OFS_CTL[0], 16'h0008);
        u_soft_master.wr32(OFS_HOLD[0], OFS_CNT[0], 32'h0001_0002);
        u_soft_master.wr16(OFS_HOLD[0], 16'h5555);
        u_soft_master.rd16(OFS_CNT[0], v);
        chk(v, 16'h0002);
        u_soft_master.rd16(OFS_HOLD[0], v);
        chk(v, 16'h0001);
        u_soft_master.rd16(OFS_CNT[1], v);
        chk(v, 16'h0001);
        u_soft_master.wr16(OFS_PER[0], 16'h0003);
        u_soft_master.wr16(OFS_PER[1], 16'h0001);
        u_soft_master.wr16(OFS_IRQ_ENABLE, 16'h0002);
        // Upper control carries a slow divide that must be ignored
        u_soft_master.wr16(OFS_CTL[1], 16'h0030);
        u_soft_master.wr16(OFS_CTL[0], 16'h8008);
        n = 0;
        while (adc_trigger !== 1'b1 && n < 40)
        begin
            tick(1);
            n++;
        end
        chk(adc_trigger, 1'b1);
        tick(1);
        chk(adc_trigger, 1'b0);
        tick(3);
        chk(tb_up, 16'h0000);
        chk(irq, 1'b1);
        u_soft_master.wr16(OFS_CTL[0], 16'h0008);
        u_soft_master.rd16(OFS_IRQ_FLAG, v);
        chk(v, 16'h0002);
        u_soft_master.wr16(OFS_IRQ_FLAG, 16'h000F);
        u_soft_master.wr16(OFS_CTL[1], 16'h0000);
        u_soft_master.wr16(OFS_CTL[0], 16'h0000);
    endtask : chained

    task automatic pair_b_and_sleep();
        int seen;
        logic [DW-1:0] s;
        u_soft_master.wr16(OFS_PER[2], 16'h0002);
        u_soft_master.wr16(OFS_PER[3], 16'h0001);
        u_soft_master.wr16(OFS_CTL[2], 16'h8000);
        u_soft_master.wr16(OFS_CTL[3], 16'h8000);
        seen = 0;
        repeat (40)
        begin
            tick(1);
            if (adc_trigger !== 1'b0)
                seen++;
        end
        chk(seen, 0);
        u_soft_master.wr16(OFS_CTL[2], 16'h0000);
        u_soft_master.wr16(OFS_CTL[3], 16'h0000);
        u_soft_master.rd16(OFS_IRQ_FLAG, v);
        chk(v, 16'h000C);
        u_soft_master.wr16(OFS_IRQ_FLAG, 16'h000F);
        u_soft_master.wr16(OFS_CTL[0], 16'h8000);
        @(posedge clk);
        sleep_mode <= 1'b1;
        tick(3);
        s = tb_lo;
        tick(20);
        chk(tb_lo, s);
        @(posedge clk);
        sleep_mode <= 1'b0;
        tick(4);
        chk(tb_lo !== s, 1'b1);
        u_soft_master.wr16(OFS_CTL[0], 16'h0000);
    endtask : pair_b_and_sleep

    task automatic gate_and_pin();
        u_soft_master.wr16(OFS_PER[0], 16'hFFFF);
        u_soft_master.wr16(OFS_CNT[0], 16'h0000);
        u_soft_master.wr16(OFS_IRQ_FLAG, 16'h000F);
        u_soft_master.wr16(OFS_CTL[0], 16'h8040);
        // Gate high for ten clocks; the sync delay cancels on both edges
        @(posedge clk);
        ext_clk_pin <= 4'h1;
        repeat (10) @(posedge clk);
        ext_clk_pin <= 4'h0;
        tick(8);
        chk(tb_lo, 16'h000A);
        u_soft_master.rd16(OFS_IRQ_FLAG, v);
        chk(v, 16'h0001);
        // Three pin rising edges on the external clock source
        u_soft_master.wr16(OFS_CTL[0], 16'h8002);
        repeat (3)
        begin
            @(posedge clk);
            ext_clk_pin <= 4'h1;
            repeat (3) @(posedge clk);
            ext_clk_pin <= 4'h0;
            repeat (2) @(posedge clk);
        end
        tick(6);
        chk(tb_lo, 16'h000D);
        u_soft_master.wr16(OFS_CTL[0], 16'hA000);
        @(posedge clk);
        idle_mode <= 1'b1;
        tick(3);
        v = tb_lo;
        tick(10);
        chk(tb_lo, v);
        u_soft_master.wr16(OFS_CTL[0], 16'h8000);
        tick(3);
        chk(tb_lo !== v, 1'b1);
        @(posedge clk);
        idle_mode <= 1'b0;
        u_soft_master.wr16(OFS_CTL[0], 16'h0000);
    endtask : gate_and_pin

    // Whole run is about a thousand cycles; a far longer wait means a hang
    initial
    begin
        #500000;
        failures++;
        close_out();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        reset_values();
        single_wrap();
        prescale();
        chained();
        pair_b_and_sleep();
        gate_and_pin();
        close_out();
    end
endmodule : test_paired_gp_timer
`default_nettype wire
